// ==== design/wdt_core.sv ====
// Purpose: watchdog counter, key clear sequence, overflow interrupt and reset
// Assumes: avalon-mm slave, system reset controller pulls reset_n after wdt_reset_req
// Notes: clear window is not implemented; clearing is allowed at any time
//
// Functional notes
// - 0x5A at pointer 0 then 0xA5 at pointer 1 clears the counter
// - pointer forced to zero on system reset and on overflow
// - any key register write with byte 0 enabled inverts the pointer, except that an overflow in the same cycle forces it to zero
// - first key written at pointer 1 is not a sequence start
// - second key at pointer 0 or without first key does not clear
// - counter counts up from reset release
// - first overflow raises an interrupt request, not a reset
// - second uncleared overflow raises the watchdog reset
// - watchdog reset sets the overflow reset flag to one
// - overflow self-clears the counter, counting continues
// - three-bit period select picks 7.8 ms up to 8000 ms
// - clearing allowed all period long; reset at twice the period
// - counter stops in stop and deep-stop modes
// - counter advances on watchdog tick edges
// - counter readable as 16-bit read-only value, reset zero
`timescale 1ns/1ps
module wdt_core
    import wdt_pkg::*;
#(
    parameter logic [31:0] TICK_DIVIDE = wdt_pkg::TICK_DIV
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic stop_mode,
    input wire logic reset_was_watchdog,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic wdt_irq_pulse,
    output logic wdt_reset_req,
    output logic irq
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic tick;
    logic run;
    assign run = clk_en & ~stop_mode;

    wdt_tick_gen #(.DIV(TICK_DIVIDE)) u_tick (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(run),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, answer registered
    logic ack_reg, ack_next;
    logic [31:0] rdata_next;
    logic req;
    logic key_wr, mode_wr, mask_wr, status_rd;
    assign req = avs_read | avs_write;
    assign key_wr = avs_write & ~ack_reg & (avs_address == ADDR_KEY) & avs_byteenable[0];
    assign mode_wr = avs_write & ~ack_reg & (avs_address == ADDR_MODE) & avs_byteenable[0];
    assign mask_wr = avs_write & ~ack_reg & (avs_address == ADDR_STATUS) & avs_byteenable[1];
    assign status_rd = avs_read & ~ack_reg & (avs_address == ADDR_STATUS);

    ////////////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0] count_reg, count_next;
    logic ptr_reg, ptr_next;
    logic armed_reg, armed_next;
    logic [2:0] period_reg, period_next;
    ovf_state_t ovf_reg, ovf_next;
    logic irq_p_next, rst_req_next;
    logic rst_flag_reg, rst_flag_next;
    logic [1:0] sticky_reg, sticky_next;
    logic [1:0] mask_reg, mask_next;
    logic irq_next;
    logic strap_done_reg, strap_done_next;
    logic overflow;
    logic do_clear;
    wdt_status_t status;

    // period minus one is the last count before wrap
    assign overflow = tick & (count_reg == period_ticks(period_reg) - 16'h1);
    assign do_clear = key_wr & ptr_reg & armed_reg & (avs_writedata[7:0] == KEY_SECOND);

    always_comb begin
        count_next = count_reg;
        ptr_next = ptr_reg;
        armed_next = armed_reg;
        period_next = period_reg;
        ovf_next = ovf_reg;
        irq_p_next = 1'b0;
        rst_req_next = wdt_reset_req;
        rst_flag_next = rst_flag_reg;
        sticky_next = sticky_reg;
        mask_next = mask_reg;
        strap_done_next = 1'b1;
        if (!strap_done_reg) begin
            rst_flag_next = reset_was_watchdog;
        end
        if (tick) begin
            count_next = count_reg + 16'h1;
        end
        if (key_wr) begin
            ptr_next = ~ptr_reg;
            // first key only counts while the pointer is zero
            armed_next = ~ptr_reg & (avs_writedata[7:0] == KEY_FIRST);
        end
        if (do_clear) begin
            count_next = {CNT_W{1'b0}};
            ovf_next = OVF_NONE;
            armed_next = 1'b0;
        end
        if (mode_wr) begin
            period_next = avs_writedata[2:0];
        end
        if (mask_wr) begin
            mask_next = avs_writedata[9:8];
        end
        if (status_rd) begin
            sticky_next = 2'h0;
        end
        if (overflow && !do_clear) begin
            count_next = {CNT_W{1'b0}};
            ptr_next = 1'b0;
            armed_next = 1'b0;
            case (ovf_reg)
                OVF_NONE: begin
                    ovf_next = OVF_ONCE;
                    irq_p_next = 1'b1;
                    sticky_next[ST_IRQ] = 1'b1;
                end
                default: begin
                    ovf_next = OVF_RESET;
                    rst_req_next = 1'b1;
                    rst_flag_next = 1'b1;
                    sticky_next[ST_RST] = 1'b1;
                end
            endcase
        end
        irq_next = |(sticky_next & mask_next);
    end

    always_comb begin
        status.clear_pending_flag = armed_reg;
        status.clear_in_progress_flag = 1'b0; // clear takes effect in the accepting cycle
        status.key_sequence_pointer = ptr_reg;
        status.overflow_reset_flag = rst_flag_reg;
        ack_next = req & ~ack_reg;
        rdata_next = 32'h0;
        if (req && !ack_reg) begin
            case (avs_address)
                ADDR_MODE: rdata_next = {29'h0, period_reg};
                ADDR_STATUS: rdata_next = {22'h0, mask_reg, 2'h0, sticky_reg, status};
                ADDR_COUNT: rdata_next = {16'h0, count_reg};
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= {CNT_W{1'b0}};
            ptr_reg <= 1'b0;
            armed_reg <= 1'b0;
            period_reg <= PERIOD_RESET;
            ovf_reg <= OVF_NONE;
            wdt_irq_pulse <= 1'b0;
            wdt_reset_req <= 1'b0;
            rst_flag_reg <= 1'b0;
            sticky_reg <= 2'h0;
            mask_reg <= MASK_RESET;
            irq <= 1'b0;
            strap_done_reg <= 1'b0;
            ack_reg <= 1'b0;
            avs_readdata <= 32'h0;
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            count_reg <= count_next;
            ptr_reg <= ptr_next;
            armed_reg <= armed_next;
            period_reg <= period_next;
            ovf_reg <= ovf_next;
            wdt_irq_pulse <= irq_p_next;
            wdt_reset_req <= rst_req_next;
            rst_flag_reg <= rst_flag_next;
            sticky_reg <= sticky_next;
            mask_reg <= mask_next;
            irq <= irq_next;
            strap_done_reg <= strap_done_next;
            ack_reg <= ack_next;
            avs_readdata <= rdata_next;
            avs_waitrequest <= ~ack_next;
        end
    end
endmodule // wdt_core

// ==== shared/wdt_pkg.sv ====
// Purpose: shared constants and types for the watchdog with clear window off
// Assumes: 32-bit avalon-mm register access, 100 MHz system clock
// Notes: word offsets are byte addresses
package wdt_pkg;
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned TICK_HZ = 1024;
    localparam logic [31:0] TICK_DIV = 32'(CLK_HZ / TICK_HZ);
    localparam logic [3:0] ADDR_KEY = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_COUNT = 4'hC;
    localparam logic [7:0] KEY_FIRST = 8'h5A;
    localparam logic [7:0] KEY_SECOND = 8'hA5;
    localparam logic [2:0] PERIOD_RESET = 3'h6;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam int unsigned CNT_W = 16;
    // status / mask layout
    localparam int unsigned ST_IRQ = 0;
    localparam int unsigned ST_RST = 1;
    typedef enum logic [1:0] {
        OVF_NONE = 2'b00,
        OVF_ONCE = 2'b01,
        OVF_RESET = 2'b11
    } ovf_state_t;
    // first member is the top bit: pending flag lands in bit 0, reset flag in bit 3
    typedef struct packed {
        logic overflow_reset_flag;
        logic key_sequence_pointer;
        logic clear_in_progress_flag;
        logic clear_pending_flag;
    } wdt_status_t;
    // overflow period in watchdog ticks, codes 000..111
    function automatic logic [CNT_W-1:0] period_ticks(input logic [2:0] sel);
        case (sel)
            3'h0: period_ticks = 16'h0008;
            3'h1: period_ticks = 16'h0010;
            3'h2: period_ticks = 16'h0020;
            3'h3: period_ticks = 16'h0040;
            3'h4: period_ticks = 16'h0080;
            3'h5: period_ticks = 16'h0200;
            3'h6: period_ticks = 16'h0800;
            default: period_ticks = 16'h2000;
        endcase
    endfunction
endpackage

// ==== design/wdt_tick_gen.sv ====
// Purpose: divides the system clock down to the watchdog tick rate
// Assumes: run gates the count, so stop modes freeze the phase
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
module wdt_tick_gen #(
    parameter logic [31:0] DIV = 32'd97656
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_next;
    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (run) begin
            if (cnt_reg >= DIV - 32'h1) begin
                cnt_next = 32'h0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 32'h1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule // wdt_tick_gen

// ==== bench/wdt_core_properties.sv ====
// Purpose: port checks of the watchdog core
// Assumes: TICK_DIVIDE equals the core instance value
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module wdt_core_properties import wdt_pkg::*; #(parameter logic [31:0] TICK_DIVIDE = 32'h4) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic stop_mode,
    input wire logic reset_was_watchdog,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic wdt_irq_pulse,
    input wire logic wdt_reset_req,
    input wire logic irq
);
    logic [15:0] cyc_reg;
    // saturates, so the lower bounds stay true on long runs
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) cyc_reg <= 16'h0;
        else if (!(&cyc_reg)) cyc_reg <= cyc_reg + 16'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_irq_pulse_short: assert property (wdt_irq_pulse |=> !wdt_irq_pulse) else $error("irq pulse long");
    a_reset_req_held: assert property (wdt_reset_req |=> wdt_reset_req) else $error("reset req dropped");
    a_ack_one_cycle: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest) else $error("ack long");
    a_ack_next_cycle: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("ack missing");
    a_irq_not_reset: assert property (wdt_irq_pulse |-> !wdt_reset_req) else $error("irq with reset");
    a_irq_not_early: assert property (wdt_irq_pulse |-> cyc_reg >= 7 * TICK_DIVIDE) else $error("irq early");
    a_reset_not_early:
        assert property ($rose(wdt_reset_req) |-> cyc_reg >= 15 * TICK_DIVIDE) else $error("reset early");
    a_count_width:
        assert property (!avs_waitrequest && avs_read && avs_address == ADDR_COUNT |-> avs_readdata[31:16] == 16'h0)
        else $error("count too wide");
endmodule // wdt_core_properties
bind wdt_core wdt_core_properties #(.TICK_DIVIDE(TICK_DIVIDE)) u_props (.clk_sys, .reset_n, .clk_en, .stop_mode,
    .reset_was_watchdog, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .wdt_irq_pulse, .wdt_reset_req, .irq);

// ==== bench/wdt_reset_ctl_model.sv ====
// Purpose: system reset controller facing the watchdog
// Assumes: por_n is the power-on reset
// Notes: holds reset three cycles and keeps the cause
`timescale 1ns/1ps
module wdt_reset_ctl_model (
    input wire logic clk_sys,
    input wire logic por_n,
    input wire logic wdt_reset_req,
    output logic reset_n,
    output logic reset_was_watchdog
);
    logic [1:0] hold_reg;
    logic cause_reg;
    // cause survives the watchdog reset, only power-on clears it
    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) {hold_reg, cause_reg} <= 3'h0;
        else if (wdt_reset_req) {hold_reg, cause_reg} <= 3'h7;
        else if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
    end
    assign reset_n = por_n && (hold_reg == 2'h0);
    assign reset_was_watchdog = por_n && cause_reg;
endmodule // wdt_reset_ctl_model

// ==== bench/wdt_core_test.sv ====
// Purpose: self-checking bench of the watchdog core
// Assumes: a tick every 4 clocks keeps periods short
// Notes: bench plays software, the model plays reset control
`timescale 1ns/1ps
module wdt_core_test;
    import wdt_pkg::*;
    typedef struct packed {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    logic clk_sys = 1'b0, por_n = 1'b0, clk_en = 1'b1, stop_mode = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q, q2;
    logic reset_n, reset_was_watchdog, avs_waitrequest, wdt_irq_pulse, wdt_reset_req, irq;
    int n_fail = 0, n_tests = 0, cyc = 0, t_irq = 0;
    row_t rows [15] = '{
        '{1'b0, 4'h4, 32'h0, 32'h6}, '{1'b1, 4'h4, 32'h1, 32'h0},
        '{1'b0, 4'h4, 32'h0, 32'h1}, '{1'b0, 4'h0, 32'h0, 32'h0},
        '{1'b0, 4'h2, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'h5A, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'h5}, '{1'b1, 4'h0, 32'hA5, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'hA5, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'h4}, '{1'b1, 4'h0, 32'h5A, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'hA5, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'h4}
    };
    wdt_reset_ctl_model u_wdt_reset_ctl_model (.clk_sys, .por_n, .wdt_reset_req, .reset_n, .reset_was_watchdog);
    wdt_core #(.TICK_DIVIDE(32'h4)) u_wdt_core (.clk_sys, .reset_n, .clk_en, .stop_mode, .reset_was_watchdog,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .wdt_irq_pulse, .wdt_reset_req, .irq);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // holds the request until waitrequest is seen low, then lets one edge pass
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        chk({29'h0, avs_waitrequest, irq, wdt_reset_req}, 32'h4);
        por_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, 4'hF);
            if (!rows[i].w) chk(q, rows[i].e);
        end
        bus(1'b1, ADDR_STATUS, 32'h100, 4'h2);
        @(posedge clk_sys iff wdt_irq_pulse === 1'b1);
        t_irq = cyc;
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_STATUS);
        chk(q, 32'h110);
        rd(ADDR_COUNT);
        chk({30'h0, q < 32'h10, irq}, 32'h2);
        @(posedge clk_sys iff wdt_reset_req === 1'b1);
        chk(cyc - t_irq, 64);
        @(posedge clk_sys iff reset_n === 1'b1);
        rd(ADDR_STATUS);
        chk(q, 32'h8);
        rd(ADDR_MODE);
        chk(q, 32'h6);
        rd(ADDR_COUNT);
        chk({31'h0, q != 32'h0}, 32'h1);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(ADDR_COUNT);
        q2 = q;
        repeat (20) @(posedge clk_sys);
        rd(ADDR_COUNT);
        chk(q, q2);
        stop_mode <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rd(ADDR_COUNT);
        chk({31'h0, q > q2}, 32'h1);
        finish_test();
    end
endmodule // wdt_core_test
